// ---- core/copy_engine_pkg.sv ----
package copy_engine_pkg;
    // ----------------------------------------
    // control register location and fields
    // ----------------------------------------
    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
    localparam int CYC_BIT = 6;
    localparam int IOC_EN_BIT = 12;
    localparam int DLY_EN_BIT = 13;
    localparam int ERR_EN_BIT = 14;
    localparam int THR_LSB = 16;
    localparam int TMO_LSB = 24;
    localparam int FIELD_W = 8;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] THR_RESET_CHAIN = 8'h01;
    localparam logic [7:0] THR_RESET_SIMPLE = 8'h00;
    localparam logic [7:0] TMO_RESET = 8'h00;
    localparam logic CTRL_BIT_RESET = 1'b0;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int DELAY_TICK_NS = 1000;
    localparam int DELAY_TICK_CYCLES = (DELAY_TICK_NS / CLK_PERIOD_NS) < 1 ?
        1 : (DELAY_TICK_NS / CLK_PERIOD_NS);
endpackage

// ---- core/delay_if.sv ----
`timescale 1ns/1ps
interface delay_if;
    logic run;
    logic restart;
    logic [7:0] period;
    logic expire;
    modport ctrl (output run, output restart, output period, input expire);
    modport timer (input run, input restart, input period, output expire);
endinterface

// ---- core/delay_timer.sv ----
`timescale 1ns/1ps
module delay_timer
    import copy_engine_pkg::*;
#(
    parameter int TICK_CYCLES = DELAY_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // control side
    delay_if.timer dly
);
    logic [15:0] div_q;
    logic tick_q;
    logic [7:0] elapsed_q;
    logic expire_q;

    // ----------------------------------------
    // tick divider
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in || !dly.run || dly.restart) begin
            div_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (div_q == 16'(TICK_CYCLES - 1)) begin
            div_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // period count
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in || !dly.run || dly.restart) begin
            elapsed_q <= 8'h00;
            expire_q <= 1'b0;
        end else if (tick_q && (elapsed_q + 8'h01 == dly.period)) begin
            elapsed_q <= 8'h00;
            expire_q <= 1'b1;
        end else begin
            elapsed_q <= tick_q ? elapsed_q + 8'h01 : elapsed_q;
            expire_q <= 1'b0;
        end
    end

    assign dly.expire = expire_q;
endmodule

// ---- core/dma_interrupt_coalescing_control.sv ----
`timescale 1ns/1ps
module dma_interrupt_coalescing_control
    import copy_engine_pkg::*;
#(
    parameter bit CHAIN_INCLUDED = 1'b1,
    parameter int TICK_CYCLES = DELAY_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // control register port
    input wire logic ctrl_wr_in,
    input wire logic [31:0] ctrl_wdata_in,
    output logic [31:0] ctrl_rdata_out,
    // engine events and status
    input wire logic complete_evt_in,
    input wire logic error_evt_in,
    input wire logic idle_in,
    input wire logic descriptor_chain_mode_in,
    // descriptor fetcher
    input wire logic desc_fetch_in,
    input wire logic desc_done_flag_in,
    output logic desc_stale_err_out,
    output logic looped_descriptor_ring_out,
    // interrupt
    output logic irq_out
);
    localparam logic [7:0] THR_RESET =
        CHAIN_INCLUDED ? THR_RESET_CHAIN : THR_RESET_SIMPLE;

    logic cyc_q;
    logic ioc_en_q;
    logic dly_en_q;
    logic err_en_q;
    logic [7:0] thr_q;
    logic [7:0] tmo_q;
    logic [7:0] cnt_q;
    logic [7:0] wr_thr;
    logic thr_load;
    logic coal_hit;
    logic dly_fire;
    logic err_hit;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic thr_write(input logic wr,
        input logic [31:0] data);
        return wr && (data[THR_LSB +: FIELD_W] != 8'h00);
    endfunction

    delay_if dly ();

    delay_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_delay_timer (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .dly(dly)
    );

    assign wr_thr = ctrl_wdata_in[THR_LSB +: FIELD_W];
    assign thr_load = thr_write(ctrl_wr_in, ctrl_wdata_in);
    assign coal_hit = complete_evt_in && ioc_en_q && (cnt_q <= 8'h01);
    assign dly_fire = dly.expire && dly_en_q && descriptor_chain_mode_in
        && (tmo_q != 8'h00);
    assign err_hit = error_evt_in && err_en_q;

    // ----------------------------------------
    // control fields
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cyc_q <= CTRL_BIT_RESET;
            ioc_en_q <= CTRL_BIT_RESET;
            dly_en_q <= CTRL_BIT_RESET;
            err_en_q <= CTRL_BIT_RESET;
            tmo_q <= TMO_RESET;
        end else if (ctrl_wr_in) begin
            cyc_q <= ctrl_wdata_in[CYC_BIT];
            ioc_en_q <= ctrl_wdata_in[IOC_EN_BIT];
            dly_en_q <= ctrl_wdata_in[DLY_EN_BIT];
            err_en_q <= ctrl_wdata_in[ERR_EN_BIT];
            tmo_q <= ctrl_wdata_in[TMO_LSB +: FIELD_W];
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            thr_q <= THR_RESET;
        end else if (thr_load) begin
            thr_q <= wr_thr;
        end
    end

    // ----------------------------------------
    // coalescing counter
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_q <= THR_RESET;
        end else if (thr_load) begin
            cnt_q <= wr_thr;
        end else if (coal_hit || dly_fire) begin
            cnt_q <= thr_q;
        end else if (complete_evt_in && ioc_en_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // ----------------------------------------
    // delay timer control
    // ----------------------------------------
    assign dly.run = dly_en_q && descriptor_chain_mode_in
        && (tmo_q != 8'h00)
        && idle_in
        && (cnt_q != thr_q);
    assign dly.restart = complete_evt_in || ctrl_wr_in;
    assign dly.period = tmo_q;

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= coal_hit || dly_fire || err_hit;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            desc_stale_err_out <= 1'b0;
            looped_descriptor_ring_out <= 1'b0;
        end else begin
            desc_stale_err_out <= desc_fetch_in && desc_done_flag_in
                && !cyc_q;
            looped_descriptor_ring_out <= cyc_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_rdata_out <= 32'h0000_0000;
        end else begin
            ctrl_rdata_out <= {tmo_q, thr_q, 1'b0, err_en_q, dly_en_q,
                ioc_en_q, 5'h00, cyc_q, 6'h00};
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    AST_CYCLIC_IGNORE: assert property (
        desc_fetch_in && desc_done_flag_in && cyc_q |=> !desc_stale_err_out)
        else $error("completed flag flagged in looped ring mode");
    AST_IOC_FIRE: assert property (
        complete_evt_in && ioc_en_q && cnt_q == 8'h01 |=> irq_out)
        else $error("threshold reached without interrupt");
    AST_DLY_CHAIN_ONLY: assert property (
        dly.run |-> descriptor_chain_mode_in && dly_en_q)
        else $error("delay timer runs outside chain mode");
    AST_ERR_FIRE: assert property (
        error_evt_in && err_en_q |=> irq_out)
        else $error("enabled error did not interrupt");
    AST_COUNT_DOWN: assert property (
        complete_evt_in && ioc_en_q && cnt_q > 8'h01 && !dly_fire
        && !ctrl_wr_in |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("counter did not decrement");
    AST_THR_ZERO_KEEP: assert property (
        ctrl_wr_in && ctrl_wdata_in[23:16] == 8'h00 |=> $stable(thr_q))
        else $error("zero threshold write took effect");
    AST_THR_RESET: assert property (@(posedge clk_in)
        disable iff (1'b0) reset_in |=> thr_q == THR_RESET)
        else $error("threshold reset value wrong");
    AST_IDLE_ONLY: assert property (
        !idle_in |-> !dly.run ##1 !dly.expire)
        else $error("delay timer counted while busy");
    AST_TMO_ZERO: assert property (
        tmo_q == 8'h00 |-> !dly_fire && !dly.run)
        else $error("zero timeout still armed timer");
    AST_RSVD_ZERO: assert property (
        ctrl_rdata_out[11:7] == 5'h00 && !ctrl_rdata_out[15])
        else $error("reserved bits read nonzero");
    AST_RELOAD: assert property (
        coal_hit && !ctrl_wr_in |=> cnt_q == thr_q)
        else $error("counter not reloaded after coalesced interrupt");
    AST_IOC_MASKED: assert property (
        complete_evt_in && !ioc_en_q && !dly_fire && !err_hit |=> !irq_out)
        else $error("disabled completion raised interrupt");
    AST_ERR_MASKED: assert property (
        error_evt_in && !err_en_q && !coal_hit && !dly_fire |=> !irq_out)
        else $error("disabled error raised interrupt");
    AST_DLY_FIRE: assert property (
        dly.expire && dly_en_q && descriptor_chain_mode_in && tmo_q != 8'h00
        |=> irq_out)
        else $error("delay expiry did not interrupt");
    AST_STALE_FIRE: assert property (
        desc_fetch_in && desc_done_flag_in && !cyc_q |=> desc_stale_err_out)
        else $error("completed descriptor not flagged");
    AST_LOOPED_OUT: assert property (
        looped_descriptor_ring_out == $past(cyc_q))
        else $error("looped ring output does not follow its bit");
    AST_THR_LOAD: assert property (
        thr_load |=> cnt_q == $past(wr_thr))
        else $error("counter not loaded from threshold write");

    COV_COALESCE: cover property (coal_hit ##1 irq_out);
    COV_DELAY: cover property (dly_fire ##1 irq_out);
    COV_ERROR: cover property (err_hit ##1 irq_out);
    COV_STALE: cover property (desc_stale_err_out);
    COV_ZERO_KEEP: cover property (ctrl_wr_in && wr_thr == 8'h00);
endmodule

// ---- sim/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk_in,
    // register write port
    output logic ctrl_wr_out,
    output logic [31:0] ctrl_wdata_out
);
    initial begin
        ctrl_wr_out = 1'b0;
        ctrl_wdata_out = 32'h0;
    end
    // one strobe per word; zero threshold only when a test asks
    task automatic write(input logic [31:0] data);
        ctrl_wr_out = 1'b1;
        ctrl_wdata_out = data;
        @(posedge clk_in);
        #1;
        ctrl_wr_out = 1'b0;
        ctrl_wdata_out = ~data;
    endtask
endmodule

// ---- sim/tb_dma_interrupt_coalescing_control.sv ----
`timescale 1ns/1ps
module tb_dma_interrupt_coalescing_control;
    import copy_engine_pkg::*;
    logic clk_in, reset_in, cmp, err, idle, chain, fetch, flag, wr;
    logic stale, looped, irq;
    logic [31:0] wdata, rdata, rdata_s;
    logic [31:0] lfsr = 32'hb5c5;
    int n_mismatch = 0;
    int compares = 0;
    int exp_q[$];
    host_model host (.clk_in(clk_in), .ctrl_wr_out(wr),
        .ctrl_wdata_out(wdata));
    dma_interrupt_coalescing_control #(.TICK_CYCLES(2)) dut (
        .clk_in(clk_in), .reset_in(reset_in), .ctrl_wr_in(wr),
        .ctrl_wdata_in(wdata), .ctrl_rdata_out(rdata),
        .complete_evt_in(cmp), .error_evt_in(err), .idle_in(idle),
        .descriptor_chain_mode_in(chain), .desc_fetch_in(fetch),
        .desc_done_flag_in(flag), .desc_stale_err_out(stale),
        .looped_descriptor_ring_out(looped), .irq_out(irq));
    dma_interrupt_coalescing_control #(.CHAIN_INCLUDED(1'b0),
        .TICK_CYCLES(2)) dut_simple (
        .clk_in(clk_in), .reset_in(reset_in), .ctrl_wr_in(wr),
        .ctrl_wdata_in(wdata), .ctrl_rdata_out(rdata_s),
        .complete_evt_in(cmp), .error_evt_in(err), .idle_in(idle),
        .descriptor_chain_mode_in(chain), .desc_fetch_in(fetch),
        .desc_done_flag_in(flag), .desc_stale_err_out(),
        .looped_descriptor_ring_out(), .irq_out());
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    function automatic int rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return int'(lfsr[1:0]);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic check(input logic [31:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    task automatic wr_chk(input logic [31:0] data, exp);
        void'(rnd());
        host.write(data | (lfsr & 32'h0000_8fbf));
        tick(2);
        check(rdata, exp, "read-back");
    endtask
    task automatic done_evt(input int k);
        repeat (k) begin
            cmp = 1'b1;
            err = 1'(rnd());
            tick(1);
            {cmp, err} = 2'b00;
            tick(1 + rnd());
        end
    endtask
    task automatic pulse(input bit on_err, input int code);
        if (code != 0) exp_q.push_back(code);
        if (on_err) err = 1'b1;
        else fetch = 1'b1;
        tick(1);
        {err, fetch} = 2'b00;
        tick(3);
    endtask
    task automatic coalesce(input int n);
        {idle, chain} = 2'(rnd());
        done_evt(n - 1);
        exp_q.push_back(1);
        done_evt(1);
        tick(2);
    endtask
    task automatic end_test(input string name, input int wait_n);
        tick(wait_n);
        check(exp_q.size(), 0, "pending event");
        $display("test %s done", name);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // monitor: irq is code 1, stale descriptor code 2
    // ----------------------------------------
    always @(negedge clk_in) begin
        if (reset_in === 1'b0 && (irq === 1'b1 || stale === 1'b1)) begin
            compares++;
            if (exp_q.size() == 0 || exp_q[0] != int'({stale, irq})) begin
                n_mismatch++;
                $display("FAIL %0t unexpected event", $time);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    initial begin
        #(5000 * 40);
        n_mismatch++;
        $display("FAIL %0t watchdog", $time);
        stop_test();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {cmp, err, idle, chain, fetch, flag} = 6'h00;
        reset_in = 1'b1;
        tick(4);
        reset_in = 1'b0;
        tick(2);
        check(rdata, 32'h0001_0000, "reset value");
        check(rdata_s, 32'h0000_0000, "simple build reset");
        wr_chk(32'h0000_ffff, 32'h0001_7040);
        check(rdata_s, 32'h0000_7040, "simple build zero write");
        check(looped, 1'b1, "looped ring");
        flag = 1'(rnd());
        pulse(1'b0, 0);
        wr_chk(32'h0003_1000, 32'h0003_1000);
        flag = 1'b1;
        pulse(1'b0, 2);
        flag = 1'(rnd());
        pulse(1'b0, flag ? 2 : 0);
        end_test("registers", 1);
        coalesce(3);
        coalesce(3);
        host.write(32'h0001_1000);
        coalesce(1);
        end_test("coalesce", 1);
        host.write(32'h0003_0000);
        done_evt(5);
        end_test("complete disabled", 3);
        host.write(32'h0001_4000);
        pulse(1'b1, 1);
        host.write(32'h0001_0000);
        pulse(1'b1, 0);
        end_test("error", 1);
        {chain, idle} = 2'b10;
        host.write(32'h0405_3000);
        done_evt(1);
        exp_q.push_back(1);
        idle = 1'b1;
        end_test("delay expiry", 14);
        idle = 1'b0;
        host.write(32'h0405_3000);
        done_evt(1);
        end_test("busy", 20);
        idle = 1'b1;
        chain = 1'b0;
        end_test("simple mode", 20);
        chain = 1'b1;
        host.write(32'h0005_3000);
        done_evt(1);
        end_test("zero timeout", 20);
        stop_test();
    end
endmodule
